/* hw/ata_tf_pkg.sv */
package ata_tf_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0]  CMD_OFS    = 8'h44;
  localparam logic [7:0]  CYLH_OFS   = 8'h4c;
  localparam logic [7:0]  DRVH_OFS   = 8'h4d;
  localparam logic [7:0]  ALT_OFS    = 8'h4e;
  localparam logic [7:0]  DRVA_OFS   = 8'h4f;
  localparam logic [7:0]  SRC_OFS    = 8'h50;
  localparam logic [7:0]  EN_OFS     = 8'h54;

  // ==========================================================
  // peripheral select codes {cs1, cs0, da2, da1, da0}
  localparam logic [4:0]  SEL_CMD    = 5'h17;
  localparam logic [4:0]  SEL_CYLH   = 5'h15;
  localparam logic [4:0]  SEL_DRVH   = 5'h16;
  localparam logic [4:0]  SEL_ALT    = 5'h0e;
  localparam logic [4:0]  SEL_DRVA   = 5'h0f;
  localparam logic [4:0]  SEL_IDLE   = 5'h00;

  // ==========================================================
  // reset and fixed values
  localparam logic [7:0]  TF_RST     = 8'h00;
  localparam logic [7:0]  CMD_RD_VAL = 8'hff;
  localparam logic [15:0] SRC_RST    = 16'h0000;
  localparam logic [15:0] EN_RST     = 16'h0000;
  localparam logic [15:0] SRC_MASK   = 16'h1ffe;
  localparam logic [15:0] RD_ZERO    = 16'h0000;

  // ==========================================================
  // source bit positions
  localparam int ODD_BIT   = 12;
  localparam int EXT_BIT   = 11;
  localparam int INT_BIT   = 10;
  localparam int PEND_BIT  = 9;
  localparam int XFER_BIT  = 8;
  localparam int WFE_BIT   = 7;
  localparam int WFF_BIT   = 6;
  localparam int RFE_BIT   = 5;
  localparam int RDD_BIT   = 4;
  localparam int BSY_BIT   = 3;
  localparam int TFRD_BIT  = 2;
  localparam int CZI_BIT   = 1;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic cmd_done;
    logic generic_dma_mode;
    logic master_dma_mode;
    logic slave_out_dir;
    logic odd_last_out;
    logic external_end_flag;
    logic short_pkt;
    logic short_zero_len;
    logic count_zero;
    logic fifo_drained;
    logic intrq;
    logic data_wr_fifo_empty;
    logic data_wr_fifo_full;
    logic data_rd_fifo_empty;
    logic data_rd_fifo_has_data;
    logic periph_busy;
    logic poll_start;
    logic taskfile_readback_done;
  } dma_evt_s;

  typedef struct packed {
    logic [4:0] sel;
    logic       wr;
    logic       rd;
    logic [7:0] data;
  } pio_cycle_s;

endpackage

/* hw/ata_task_file_dma_irq_status.sv */
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps

// Function
// - cylinder-high at 4ch, select cs1 high cs0 low da 101, resets zero.
// - drive/head at 4dh, select cs1 high cs0 low da 110, read/write.
// - command at 44h, select da 111, write-only, reads return ffh.
// - alternate status/control at 4eh, select cs1 low cs0 high da 110.
// - drive address at 4fh, select cs1 low cs0 high da 111.
// - 16-bit source register at 50h; bits 15..13 and 0 reserved, reset zero.
// - source bits 9..4 refreshed whenever a dma command finishes.
// - writing one clears that source bit; zeros leave bits unchanged.
// - odd-byte flag set on final odd out packet, slave out mode only.
// - external end flag set on external end, generic mode only.
// - internal end flag set when an internal end is detected.
// - pending flag set on interrupt request from the peripheral.
// - complete flag set at counter zero, generic or master mode only.
// - bit 7 set when the data write fifo is empty.
// - bit 6 set when write fifo full; software then stops writing.
// - bit 5 set when read fifo empty; software then stops reading.
// - bit 4 set when the data fifo holds unread data.
// - bit 3 set when peripheral busy drops; polling then stops.
// - bit 2 set when task file readback command has finished.
// - bit 1 set when fifo drained, count zero and interrupt seen.
// - internal end and complete flags combine to tell short or normal finish.
// - a zero-length packet never sets the internal end flag, but holds off the complete flag like a short packet.
// - 16-bit enable register at 54h gates sources; resets disabled.
module ata_task_file_dma_irq_status (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   bus_rst,
  input  wire logic [7:0]             addr,
  input  wire logic [15:0]            wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [15:0]            rdata_q,
  input  wire ata_tf_pkg::dma_evt_s   evt,
  output ata_tf_pkg::pio_cycle_s      pio_q,
  output logic                        irq_q,
  output logic                        polling_q
);
  import ata_tf_pkg::*;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // address decode
  wire logic        hit_cmd;
  wire logic        hit_cylh;
  wire logic        hit_drvh;
  wire logic        hit_alt;
  wire logic        hit_drva;
  wire logic        hit_src;
  wire logic        hit_en;
  wire logic        hit_tf;
  wire logic        tf_acc;
  wire logic [4:0]  tf_sel;

  assign hit_cmd  = (addr == CMD_OFS);
  assign hit_cylh = (addr == CYLH_OFS);
  assign hit_drvh = (addr == DRVH_OFS);
  assign hit_alt  = (addr == ALT_OFS);
  assign hit_drva = (addr == DRVA_OFS);
  assign hit_src  = (addr == SRC_OFS);
  assign hit_en   = (addr == EN_OFS);
  assign hit_tf   = hit_cmd | hit_cylh | hit_drvh | hit_alt | hit_drva;
  assign tf_acc   = (wr | rd) & hit_tf & ~bus_rst;

  // select code per register
  assign tf_sel = hit_cylh ? SEL_CYLH :
                  hit_drvh ? SEL_DRVH :
                  hit_cmd  ? SEL_CMD  :
                  hit_alt  ? SEL_ALT  :
                  hit_drva ? SEL_DRVA :
                  SEL_IDLE;

  // ==========================================================
  // task file shadow registers
  logic [7:0]  cmd_q;
  logic [7:0]  cylh_q;
  logic [7:0]  drvh_q;
  logic [7:0]  alt_q;
  logic [7:0]  drva_q;
  logic [15:0] en_q;
  wire logic [7:0]  cmd_d;
  wire logic [7:0]  cylh_d;
  wire logic [7:0]  drvh_d;
  wire logic [7:0]  alt_d;
  wire logic [7:0]  drva_d;
  wire logic [15:0] en_d;

  // software keeps command write last; block just forwards each write
  assign cmd_d  = bus_rst ? TF_RST : (wr & hit_cmd)  ? wdata[7:0] : cmd_q;
  assign cylh_d = bus_rst ? TF_RST : (wr & hit_cylh) ? wdata[7:0] : cylh_q;
  assign drvh_d = bus_rst ? TF_RST : (wr & hit_drvh) ? wdata[7:0] : drvh_q;
  assign alt_d  = bus_rst ? TF_RST : (wr & hit_alt)  ? wdata[7:0] : alt_q;
  assign drva_d = bus_rst ? TF_RST : (wr & hit_drva) ? wdata[7:0] : drva_q;
  assign en_d   = bus_rst ? EN_RST : (wr & hit_en) ? (wdata & SRC_MASK) : en_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_q  <= TF_RST;
      cylh_q <= TF_RST;
      drvh_q <= TF_RST;
      alt_q  <= TF_RST;
      drva_q <= TF_RST;
      en_q   <= EN_RST;
    end else begin
      cmd_q  <= cmd_d;
      cylh_q <= cylh_d;
      drvh_q <= drvh_d;
      alt_q  <= alt_d;
      drva_q <= drva_d;
      en_q   <= en_d;
    end
  end

  // ==========================================================
  // pio cycle generation
  pio_cycle_s pio_d;

  always_comb begin
    pio_d      = '0;
    pio_d.sel  = tf_acc ? tf_sel : SEL_IDLE;
    pio_d.wr   = tf_acc & wr;
    pio_d.rd   = tf_acc & rd;
    pio_d.data = (tf_acc & wr) ? wdata[7:0] : TF_RST;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pio_q <= '0;
    end else begin
      pio_q <= pio_d;
    end
  end

  // ==========================================================
  // event edge detection
  logic intrq_q;
  logic wfe_q;
  logic wff_q;
  logic rfe_q;
  logic rdd_q;
  logic intrq_seen_q;
  logic poll_q;
  wire logic intrq_rise;
  wire logic wfe_rise;
  wire logic wff_rise;
  wire logic rfe_rise;
  wire logic rdd_rise;
  wire logic busy_done;
  wire logic seen_d;
  wire logic poll_d;

  assign intrq_rise = evt.intrq & ~intrq_q;
  assign wfe_rise   = evt.data_wr_fifo_empty & ~wfe_q;
  assign wff_rise   = evt.data_wr_fifo_full & ~wff_q;
  assign rfe_rise   = evt.data_rd_fifo_empty & ~rfe_q;
  assign rdd_rise   = evt.data_rd_fifo_has_data & ~rdd_q;
  assign busy_done  = poll_q & ~evt.periph_busy;
  // polling stops once busy has dropped
  assign poll_d     = bus_rst ? 1'b0 : evt.poll_start | (poll_q & evt.periph_busy);
  assign seen_d     = bus_rst ? 1'b0 : intrq_rise | (intrq_seen_q & ~evt.cmd_done);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      intrq_q      <= 1'b0;
      wfe_q        <= 1'b0;
      wff_q        <= 1'b0;
      rfe_q        <= 1'b0;
      rdd_q        <= 1'b0;
      intrq_seen_q <= 1'b0;
      poll_q       <= 1'b0;
    end else begin
      intrq_q      <= evt.intrq;
      wfe_q        <= evt.data_wr_fifo_empty;
      wff_q        <= evt.data_wr_fifo_full;
      rfe_q        <= evt.data_rd_fifo_empty;
      rdd_q        <= evt.data_rd_fifo_has_data;
      intrq_seen_q <= seen_d;
      poll_q       <= poll_d;
    end
  end

  // ==========================================================
  // dma interrupt source register
  logic [15:0] src_q;
  logic [15:0] set_vec;
  wire logic [15:0] src_clr;
  wire logic [15:0] src_d;
  wire logic        refresh;
  wire logic        xfer_mode;
  wire logic        real_short;
  wire logic        czi_hit;

  assign refresh    = evt.cmd_done;
  assign xfer_mode  = evt.generic_dma_mode | evt.master_dma_mode;
  assign real_short = evt.short_pkt & ~evt.short_zero_len;
  assign czi_hit    = evt.fifo_drained & evt.count_zero & (intrq_seen_q | intrq_rise);

  always_comb begin
    set_vec = '0;
    set_vec[ODD_BIT]  = evt.odd_last_out & evt.slave_out_dir;
    set_vec[EXT_BIT]  = evt.external_end_flag & evt.generic_dma_mode;
    // internal end and complete combine into short/normal finish
    set_vec[INT_BIT]  = real_short;
    set_vec[PEND_BIT] = intrq_rise | (refresh & evt.intrq);
    set_vec[XFER_BIT] = evt.count_zero & xfer_mode & (refresh | ~evt.short_pkt);
    set_vec[WFE_BIT]  = wfe_rise | (refresh & evt.data_wr_fifo_empty);
    set_vec[WFF_BIT]  = wff_rise | (refresh & evt.data_wr_fifo_full);
    set_vec[RFE_BIT]  = rfe_rise | (refresh & evt.data_rd_fifo_empty);
    set_vec[RDD_BIT]  = rdd_rise | (refresh & evt.data_rd_fifo_has_data);
    set_vec[BSY_BIT]  = busy_done;
    set_vec[TFRD_BIT] = evt.taskfile_readback_done;
    set_vec[CZI_BIT]  = czi_hit;
  end

  // write-one clears, set wins over clear
  assign src_clr = (wr & hit_src) ? wdata : RD_ZERO;
  assign src_d   = bus_rst ? SRC_RST : ((src_q & ~src_clr) | set_vec) & SRC_MASK;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      src_q <= SRC_RST;
    end else begin
      src_q <= src_d;
    end
  end

  // ==========================================================
  // read path and status outputs
  wire logic [15:0] rdata_d;
  wire logic        irq_d;

  assign rdata_d = ~rd      ? RD_ZERO :
                   hit_cmd  ? {8'h00, CMD_RD_VAL} :
                   hit_cylh ? {8'h00, cylh_q} :
                   hit_drvh ? {8'h00, drvh_q} :
                   hit_alt  ? {8'h00, alt_q} :
                   hit_drva ? {8'h00, drva_q} :
                   hit_src  ? src_q :
                   hit_en   ? en_q :
                   RD_ZERO;
  assign irq_d   = ~bus_rst & |(src_q & en_q);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q   <= RD_ZERO;
      irq_q     <= 1'b0;
      polling_q <= 1'b0;
    end else begin
      rdata_q   <= rdata_d;
      irq_q     <= irq_d;
      polling_q <= poll_d;
    end
  end

  // ==========================================================
  // assertions
  sequence s_tf_acc(logic hit);
    (wr | rd) && hit && !bus_rst;
  endsequence

  sequence s_pio_out(logic [4:0] code);
    (pio_q.wr || pio_q.rd) && pio_q.sel == code;
  endsequence

  property p_cylh_sel;
    s_tf_acc(hit_cylh) |=> s_pio_out(SEL_CYLH);
  endproperty
  a_cylh_sel: assert property (p_cylh_sel) else $error("cylinder-high select wrong");

  property p_drvh_sel;
    s_tf_acc(hit_drvh) |=> s_pio_out(SEL_DRVH);
  endproperty
  a_drvh_sel: assert property (p_drvh_sel) else $error("drive/head select wrong");

  property p_cmd_read;
    rd && hit_cmd |=> rdata_q == 16'h00ff;
  endproperty
  a_cmd_read: assert property (p_cmd_read) else $error("command read not all ones");

  property p_alt_sel;
    s_tf_acc(hit_alt) |=> s_pio_out(SEL_ALT) && pio_q.rd == $past(rd);
  endproperty
  a_alt_sel: assert property (p_alt_sel) else $error("alt status select wrong");

  property p_drva_sel;
    s_tf_acc(hit_drva) |=> s_pio_out(SEL_DRVA);
  endproperty
  a_drva_sel: assert property (p_drva_sel) else $error("drive address select wrong");

  property p_src_rsvd;
    bus_rst |=> src_q == 16'h0000 ##1 (src_q & 16'he001) == 16'h0000;
  endproperty
  a_src_rsvd: assert property (p_src_rsvd) else $error("source reset or reserved wrong");

  property p_w1c;
    wr && hit_src && !bus_rst && set_vec == 16'h0000
      |=> src_q == ($past(src_q) & ~$past(wdata));
  endproperty
  a_w1c: assert property (p_w1c) else $error("write-one clear wrong");

  property p_zero_len;
    evt.short_pkt && evt.short_zero_len && !src_q[INT_BIT] && !bus_rst
      |=> !src_q[INT_BIT];
  endproperty
  a_zero_len: assert property (p_zero_len) else $error("zero-length taken as short");

  property p_external_end_flag;
    evt.external_end_flag && !bus_rst |=> src_q[EXT_BIT] == $past(evt.generic_dma_mode)
      || $past(src_q[EXT_BIT]);
  endproperty
  a_external_end_flag: assert property (p_external_end_flag) else $error("external end flag wrong");

  property p_pending;
    $rose(evt.intrq) && !bus_rst |=> src_q[PEND_BIT];
  endproperty
  a_pending: assert property (p_pending) else $error("pending flag not set");

  sequence s_busy_drop;
    poll_q && !evt.periph_busy && !evt.poll_start && !bus_rst;
  endsequence

  property p_busy_done;
    s_busy_drop |=> src_q[BSY_BIT] && !polling_q;
  endproperty
  a_busy_done: assert property (p_busy_done) else $error("busy done not reported");

  property p_irq_gate;
    (src_q & en_q) != 16'h0000 && !bus_rst |=> irq_q;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("enabled source gave no request");

  property p_cmd_pio;
    wr && hit_cmd && !bus_rst |=> pio_q.wr && pio_q.data == $past(wdata[7:0]) ##1 !pio_q.wr
      || $past(wr);
  endproperty
  a_cmd_pio: assert property (p_cmd_pio) else $error("command write gave no pio cycle");

  property p_cmd_store;
    wr && hit_cmd && !bus_rst |=> cmd_q == $past(wdata[7:0]);
  endproperty
  a_cmd_store: assert property (p_cmd_store) else $error("command not stored");

  property p_odd_set;
    evt.odd_last_out && evt.slave_out_dir && !bus_rst |=> src_q[ODD_BIT];
  endproperty
  a_odd_set: assert property (p_odd_set) else $error("odd flag not set");

  property p_int_end;
    evt.short_pkt && !evt.short_zero_len && !bus_rst |=> src_q[INT_BIT];
  endproperty
  a_int_end: assert property (p_int_end) else $error("internal end not set");

  property p_xfer_mode;
    !src_q[XFER_BIT] && !evt.generic_dma_mode && !evt.master_dma_mode && !bus_rst
      |=> !src_q[XFER_BIT];
  endproperty
  a_xfer_mode: assert property (p_xfer_mode) else $error("complete without mode");

  property p_refresh;
    evt.cmd_done && evt.data_wr_fifo_empty && !bus_rst |=> src_q[WFE_BIT];
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh missed bit 7");

  property p_rd_fifo;
    $rose(evt.data_rd_fifo_has_data) && !bus_rst |=> src_q[RDD_BIT];
  endproperty
  a_rd_fifo: assert property (p_rd_fifo) else $error("unread data flag not set");

  property p_readback;
    evt.taskfile_readback_done && !bus_rst |=> src_q[TFRD_BIT];
  endproperty
  a_readback: assert property (p_readback) else $error("readback flag not set");

  property p_czi_set;
    evt.fifo_drained && evt.count_zero && intrq_seen_q && !bus_rst |=> src_q[CZI_BIT];
  endproperty
  a_czi_set: assert property (p_czi_set) else $error("count-zero flag not set");

  property p_czi_only;
    !src_q[CZI_BIT] && !evt.count_zero && !bus_rst |=> !src_q[CZI_BIT];
  endproperty
  a_czi_only: assert property (p_czi_only) else $error("count-zero flag too early");

endmodule

/* tb/atapi_periph_model.sv */
`timescale 1ns/100ps

// ==========================================
// atapi peripheral: logs pio cycles, busy then intrq after a command
module atapi_periph_model #(
  parameter int BUSY_CYC = 12
) (
  input  wire logic                  clk,
  input  wire ata_tf_pkg::pio_cycle_s pio,
  output logic                       intrq,
  output logic                       busy,
  output logic [4:0]                 last_sel,
  output logic [7:0]                 last_data,
  output int                         n_wr
);
  import ata_tf_pkg::*;
  int cnt;

  initial begin
    intrq = 1'b0;
    busy = 1'b0;
    last_sel = 5'h00;
    last_data = 8'h00;
    n_wr = 0;
    cnt = 0;
  end

  always @(posedge clk) begin
    if (pio.wr || pio.rd) begin
      last_sel <= pio.sel;
      last_data <= pio.data;
    end
    if (pio.wr) begin
      n_wr <= n_wr + 1;
    end
    if (pio.wr && pio.sel == SEL_CMD) begin
      busy <= 1'b1;
      cnt <= BUSY_CYC;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      busy <= 1'b0;
      intrq <= 1'b1;
      cnt <= 0;
    end
    if (pio.rd && pio.sel == SEL_CMD) begin
      intrq <= 1'b0;
    end
  end
endmodule

/* tb/testbench.sv */
`timescale 1ns/100ps

`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end

module testbench;
  import ata_tf_pkg::*;
  logic       clk;
  logic       sys_rst;
  logic       bus_rst;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic       wr;
  logic       rd;
  logic [15:0] rdata_q;
  dma_evt_s   evt_q;
  dma_evt_s   evt;
  pio_cycle_s pio_q;
  pio_cycle_s rd_pio;
  logic       irq_q;
  logic       polling_q;
  logic       m_intrq;
  logic       m_busy;
  logic [4:0] m_sel;
  logic [7:0] m_data;
  int         m_nwr;
  int         failures;
  int         checked;

  always_comb begin
    evt = evt_q;
    evt.intrq = m_intrq;
    evt.periph_busy = m_busy;
  end

  ata_task_file_dma_irq_status dut (
    .clk(clk), .sys_rst(sys_rst), .bus_rst(bus_rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata_q(rdata_q), .evt(evt), .pio_q(pio_q), .irq_q(irq_q),
    .polling_q(polling_q));

  atapi_periph_model peripheral (
    .clk(clk), .pio(pio_q), .intrq(m_intrq), .busy(m_busy), .last_sel(m_sel),
    .last_data(m_data), .n_wr(m_nwr));

  // ==========================================
  // bus tasks
  task automatic report_and_stop();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] x, input string n);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    rd_pio = pio_q;
    `CHK(n, x, rdata_q)
  endtask

  task automatic ev_case(input string n, input dma_evt_s e, input logic [15:0] x);
    @(posedge clk);
    evt_q <= e;
    @(posedge clk);
    evt_q <= '0;
    rd_chk(SRC_OFS, x, n);
    `CHK("irq", x != 16'h0000, irq_q)
    wr_reg(SRC_OFS, x);
    rd_chk(SRC_OFS, 16'h0000, n);
  endtask

  // ==========================================
  // scenarios
  task automatic sc_reset_vals();
    logic [7:0] a [7] = '{CYLH_OFS, DRVH_OFS, ALT_OFS, DRVA_OFS, SRC_OFS, EN_OFS, CMD_OFS};
    for (int i = 0; i < 7; i++) begin
      rd_chk(a[i], (i == 6) ? 16'h00ff : 16'h0000, "reset val");
    end
  endtask

  task automatic sc_taskfile();
    logic [7:0] a [4] = '{CYLH_OFS, DRVH_OFS, ALT_OFS, DRVA_OFS};
    logic [4:0] s [4] = '{SEL_CYLH, SEL_DRVH, SEL_ALT, SEL_DRVA};
    int n;
    for (int i = 0; i < 4; i++) begin
      wr_reg(a[i], 16'ha55a + 16'(i));
      rd_chk(a[i], 16'h005a + 16'(i), "tf read");
      `CHK("pio wr sel", s[i], m_sel)
      `CHK("pio wr data", 8'h5a + 8'(i), m_data)
      `CHK("pio rd sel", s[i], rd_pio.sel)
    end
    n = m_nwr;
    wr_reg(8'h60, 16'h1234);
    rd_chk(8'h60, 16'h0000, "unmapped");
    `CHK("pio count", n, m_nwr)
  endtask

  task automatic sc_events();
    wr_reg(EN_OFS, 16'hffff);
    wr_reg(SRC_OFS, 16'hffff);
    rd_chk(EN_OFS, 16'h1ffe, "enable");
    rd_chk(SRC_OFS, 16'h0000, "w1c");
    ev_case("odd", '{odd_last_out: 1'b1, slave_out_dir: 1'b1, default: 1'b0}, 16'h1000);
    ev_case("odd in", '{odd_last_out: 1'b1, default: 1'b0}, 16'h0000);
    ev_case("ext", '{external_end_flag: 1'b1, generic_dma_mode: 1'b1, default: 1'b0}, 16'h0800);
    ev_case("ext off", '{external_end_flag: 1'b1, default: 1'b0}, 16'h0000);
    ev_case("short", '{short_pkt: 1'b1, default: 1'b0}, 16'h0400);
    ev_case("zlp", '{short_pkt: 1'b1, short_zero_len: 1'b1, default: 1'b0}, 16'h0000);
    ev_case("done", '{count_zero: 1'b1, master_dma_mode: 1'b1, default: 1'b0}, 16'h0100);
    ev_case("short zero", '{count_zero: 1'b1, generic_dma_mode: 1'b1, short_pkt: 1'b1,
            cmd_done: 1'b1, default: 1'b0}, 16'h0500);
    ev_case("wf full", '{data_wr_fifo_full: 1'b1, default: 1'b0}, 16'h0040);
    ev_case("rf empty", '{data_rd_fifo_empty: 1'b1, default: 1'b0}, 16'h0020);
    ev_case("tf rd", '{taskfile_readback_done: 1'b1, default: 1'b0}, 16'h0004);
    ev_case("done off", '{count_zero: 1'b1, default: 1'b0}, 16'h0000);
    @(posedge clk);
    evt_q <= '{taskfile_readback_done: 1'b1, default: 1'b0};
    wr_reg(SRC_OFS, 16'h0004);
    evt_q <= '0;
    rd_chk(SRC_OFS, 16'h0004, "set wins");
    wr_reg(SRC_OFS, 16'h0004);
    @(posedge clk);
    evt_q <= '{data_wr_fifo_empty: 1'b1, data_rd_fifo_has_data: 1'b1, default: 1'b0};
    wr_reg(SRC_OFS, 16'h0010);
    rd_chk(SRC_OFS, 16'h0080, "part clr");
    wr_reg(SRC_OFS, 16'h0080);
    rd_chk(SRC_OFS, 16'h0000, "level held");
    ev_case("refresh", '{cmd_done: 1'b1, data_wr_fifo_empty: 1'b1, data_rd_fifo_has_data: 1'b1,
            default: 1'b0}, 16'h0090);
  endtask

  task automatic sc_poll();
    int i;
    wr_reg(CMD_OFS, 16'h00a0);
    rd_chk(CMD_OFS, 16'h00ff, "cmd read");
    `CHK("cmd sel", SEL_CMD, m_sel)
    `CHK("cmd data", 8'ha0, m_data)
    `CHK("cmd rd", 1'b1, rd_pio.rd)
    @(posedge clk);
    evt_q <= '{poll_start: 1'b1, default: 1'b0};
    @(posedge clk);
    evt_q <= '0;
    #1;
    `CHK("polling", 1'b1, polling_q)
    for (i = 0; i < 40 && polling_q !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 40) begin
      failures++;
      report_and_stop();
    end
    rd_chk(SRC_OFS, 16'h0208, "busy done");
    wr_reg(SRC_OFS, 16'h0208);
    rd_chk(CMD_OFS, 16'h00ff, "cmd read");
    ev_case("cz irq", '{cmd_done: 1'b1, count_zero: 1'b1, fifo_drained: 1'b1, default: 1'b0},
            16'h0002);
  endtask

  task automatic sc_busrst();
    wr_reg(CYLH_OFS, 16'h00c3);
    rd_chk(CYLH_OFS, 16'h00c3, "pre rst");
    @(posedge clk);
    evt_q <= '{taskfile_readback_done: 1'b1, default: 1'b0};
    @(posedge clk);
    evt_q <= '0;
    bus_rst <= 1'b1;
    @(posedge clk);
    bus_rst <= 1'b0;
    #1;
    `CHK("irq rst", 1'b0, irq_q)
    rd_chk(SRC_OFS, 16'h0000, "bus rst");
    rd_chk(CYLH_OFS, 16'h0000, "bus rst");
    rd_chk(EN_OFS, 16'h0000, "bus rst");
  endtask

  // ==========================================
  // main sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    failures = 0;
    checked = 0;
    sys_rst = 1'b1;
    bus_rst = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    evt_q = '0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    sc_reset_vals();
    sc_taskfile();
    sc_events();
    sc_poll();
    sc_busrst();
    report_and_stop();
  end
endmodule
